// [design/mrc_map.svh]
// Function
// - Act only as I2C slave at seven-bit address 0001101.
// - Serial bus runs in standard 100kHz and fast 400kHz modes.
// - Mode field of control register 09H selects operation; standby after reset.
// - Mode 01 measures continuously and stores each result arriving while unlocked in data registers.
// - Rate code 01 gives 50Hz; range code 01 gives plus or minus 8 gauss.
// - Oversampling field resets to 00; 10 selects 128, 11 selects 64.
// - Control value 0x1D selects oversampling 512, 8 gauss, 200Hz, continuous.
// - Compensated results reach the data registers by default without host action.
// - Temperature reading is shown in registers 07H and 08H.
// - Status bit 0 at 06H reads 1 while a new result set is ready.
// - Reading any of the six magnetic bytes clears ready and overrun.
// - Any data byte read blocks data updates until byte 05H is read.
// - Reads during a measurement return old results and never set ready.
// - Unread set is overwritten, ready stays, overrun set; reading 06H clears it.
// - Result ending while locked is discarded and sets overrun until 06H or a magnetic byte is read.
// - Ready pin signals each completed measurement unless bit 0 of 0AH is 1; a result discarded while locked does not raise it.
// - Standby does no measurement, halts timing, keeps registers, serves the bus.
// - Writing 0x80 to 0AH soft resets registers and returns to standby.
// - Ready pin idles low, rises with new data, stays high until read.
// - Each axis result is 16-bit two's complement, saturating at -32768 and 32767.
// - Multi-byte reads advance the register pointer after every byte.
// - With 0AH bit 6 set, reads started in 00H to 06H wrap after 06H.
`ifndef MRC_MAP_SVH
`define MRC_MAP_SVH

// Bus address
`define MRC_DEV_ADDR 7'h0D

// Register offsets
`define MRC_OFS_X_LOW 8'h00
`define MRC_OFS_Z_HIGH 8'h05
`define MRC_OFS_STATUS 8'h06
`define MRC_OFS_TEMP_LOW 8'h07
`define MRC_OFS_TEMP_HIGH 8'h08
`define MRC_OFS_CTRL 8'h09
`define MRC_OFS_RST_INT 8'h0A
`define MRC_OFS_SR_PERIOD 8'h0B

// Field positions
`define MRC_ST_READY_BIT 0
`define MRC_ST_CLIP_BIT 1
`define MRC_ST_OVERRUN_BIT 2
`define MRC_RI_INT_DIS_BIT 0
`define MRC_RI_ROLL_BIT 6
`define MRC_RI_SOFT_RST_BIT 7

// Codes and reset values
`define MRC_MODE_CONT 2'b01
`define MRC_CTRL_RST 8'h00
`define MRC_RST_INT_RST 8'h00
`define MRC_SR_PERIOD_RST 8'h00

// Output rate periods in microseconds per rate code, and clock rate
`define MRC_PERIOD_US_R0 100000
`define MRC_PERIOD_US_R1 20000
`define MRC_PERIOD_US_R2 10000
`define MRC_PERIOD_US_R3 5000
`define MRC_CLK_MHZ 100

`endif

// [design/mrc_pkg.sv]
package mrc_pkg;

	// Raw width of the front end's compensated axis words
	localparam int RAW_W = 20;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] oversample_ratio;
		logic [1:0] field_range;
		logic [1:0] output_rate;
		logic [1:0] mode;
	} mrc_ctrl_t;

	// One compensated result set from the front end
	typedef struct packed {
		logic signed [RAW_W-1:0] x;
		logic signed [RAW_W-1:0] y;
		logic signed [RAW_W-1:0] z;
		logic [15:0] temp;
	} mrc_sample_t;

	// Serial engine states, Gray coded along the usual path
	typedef enum logic [2:0] {
		MRC_IDLE = 3'b000,
		MRC_ADDR = 3'b001,
		MRC_ACK_ADDR = 3'b011,
		MRC_RX = 3'b010,
		MRC_ACK_RX = 3'b110,
		MRC_TX = 3'b111,
		MRC_ACK_TX = 3'b101
	} mrc_state_t;

endpackage

// [design/mrc_rate_timer.sv]
`timescale 1ns/10ps
`include "mrc_map.svh"
module mrc_rate_timer #(
	parameter int unsigned PERIOD0 = `MRC_PERIOD_US_R0 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD1 = `MRC_PERIOD_US_R1 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD2 = `MRC_PERIOD_US_R2 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD3 = `MRC_PERIOD_US_R3 * `MRC_CLK_MHZ
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic [1:0] rate_sel,
	// Measurement start strobe
	output logic tick
);
	// Refuse periods the counter cannot hold
	if (PERIOD0 < 2 || PERIOD1 < 2 || PERIOD2 < 2 || PERIOD3 < 2 ||
		PERIOD0 >= 2**24 || PERIOD1 >= 2**24 || PERIOD2 >= 2**24 || PERIOD3 >= 2**24)
	begin : g_bad
		$error("mrc_rate_timer: period out of range");
	end

	logic [23:0] cnt;
	wire [23:0] last_sel = (rate_sel == 2'b00) ? 24'(PERIOD0 - 1) :
		(rate_sel == 2'b01) ? 24'(PERIOD1 - 1) :
		(rate_sel == 2'b10) ? 24'(PERIOD2 - 1) : 24'(PERIOD3 - 1);
	wire at_last = (cnt >= last_sel);

	// Interval counter; held cleared while halted
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 24'h000000;
			tick <= 1'b0;
		end
		else
		begin
			cnt <= (!run || at_last) ? 24'h000000 : cnt + 24'h000001;
			tick <= run && at_last;
		end
	end
endmodule

// [design/mrc_sat16.sv]
`timescale 1ns/10ps
module mrc_sat16 #(
	parameter int IN_W = 20
) (
	// Wide signed input
	input wire logic signed [IN_W-1:0] raw,
	// Saturated 16-bit result
	output logic [15:0] value,
	output logic clipped
);
	// Refuse inputs narrower than the result
	if (IN_W < 16)
	begin : g_bad
		$error("mrc_sat16: input narrower than 16 bits");
	end

	// Clamp to the 16-bit two's complement range
	wire hi = (raw > $signed(IN_W'(32767)));
	wire lo = (raw < -$signed(IN_W'(32768)));
	assign clipped = hi || lo;
	assign value = hi ? 16'h7FFF : (lo ? 16'h8000 : raw[15:0]);
endmodule

// [design/mrc_top.sv]
`timescale 1ns/10ps
`include "mrc_map.svh"
module mrc_top #(
	parameter logic [6:0] DEV_ADDR = `MRC_DEV_ADDR,
	parameter int unsigned PERIOD0 = `MRC_PERIOD_US_R0 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD1 = `MRC_PERIOD_US_R1 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD2 = `MRC_PERIOD_US_R2 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD3 = `MRC_PERIOD_US_R3 * `MRC_CLK_MHZ
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Serial bus pins, data is open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Data-ready pin
	output logic result_ready_pin,
	// Front end control
	output logic afe_start,
	output mrc_pkg::mrc_ctrl_t afe_cfg,
	output logic [7:0] afe_sr_period,
	// Front end results
	input wire logic afe_valid,
	input wire mrc_pkg::mrc_sample_t afe_sample
);
	// Serial engine state
	mrc_pkg::mrc_state_t state;
	logic scl_q;
	logic sda_q;
	logic [3:0] cnt;
	logic [7:0] shreg;
	logic [7:0] txbyte;
	logic [7:0] ptr;
	logic rw;
	logic first;
	logic nack;
	logic roll_on;
	logic oe;

	// Register file
	mrc_pkg::mrc_ctrl_t ctrl;
	logic int_dis;
	logic roll_en;
	logic [7:0] sr_period;
	logic [15:0] mag_x;
	logic [15:0] mag_y;
	logic [15:0] mag_z;
	logic [15:0] temp;
	logic result_ready_flag;
	logic result_overrun_flag;
	logic clip_flag;
	logic lock;
	logic pin_q;
	logic timer_tick;

	// Bus line events; pins are synchronous, only previous levels kept
	wire scl_rise = scl_in && !scl_q;
	wire scl_fall = !scl_in && scl_q;
	wire bus_start = scl_in && scl_q && sda_q && !sda_in;
	wire bus_stop = scl_in && scl_q && !sda_q && sda_in;

	// Byte boundaries and address match
	wire byte_done = scl_fall && (cnt == 4'h8);
	wire addr_hit = (shreg[7:1] == DEV_ADDR);

	// Register access strobes
	wire wr_fire = byte_done && (state == mrc_pkg::MRC_RX) && !first;
	wire rd_fire = scl_fall && (((state == mrc_pkg::MRC_ACK_ADDR) && rw) ||
		((state == mrc_pkg::MRC_ACK_TX) && !nack));

	// Pointer advance with optional wrap inside the result block
	wire roll_now = (state == mrc_pkg::MRC_ACK_ADDR) ? (ptr <= `MRC_OFS_STATUS) : roll_on;
	wire wrap = roll_en && roll_now && (ptr == `MRC_OFS_STATUS);
	wire [7:0] next_ptr = wrap ? `MRC_OFS_X_LOW : ptr + 8'h01;

	// Register write decode
	wire wr_ctrl = wr_fire && (ptr == `MRC_OFS_CTRL);
	wire wr_ri = wr_fire && (ptr == `MRC_OFS_RST_INT);
	wire wr_sr = wr_fire && (ptr == `MRC_OFS_SR_PERIOD);
	wire soft_rst = wr_ri && shreg[`MRC_RI_SOFT_RST_BIT];

	// Read side effects
	wire data_acc = rd_fire && (ptr <= `MRC_OFS_Z_HIGH);
	wire zhi_acc = rd_fire && (ptr == `MRC_OFS_Z_HIGH);
	wire st_acc = rd_fire && (ptr == `MRC_OFS_STATUS);

	// Measurement completion, accepted only while measuring
	wire measuring = (ctrl.mode == `MRC_MODE_CONT);
	wire meas_done = afe_valid && measuring;
	wire update = meas_done && !lock;

	// Flag next values; a completion wins over a read in the same cycle
	wire next_ready = update || (result_ready_flag && !data_acc);
	wire next_overrun = (meas_done && (lock || result_ready_flag)) ||
		(result_overrun_flag && !data_acc && !st_acc);
	wire next_lock = (data_acc && !zhi_acc) || (lock && !zhi_acc);

	// Saturated axis words
	logic [15:0] sat_val [0:2];
	logic [2:0] sat_clip;
	wire signed [mrc_pkg::RAW_W-1:0] raw_axis [0:2];
	assign raw_axis[0] = afe_sample.x;
	assign raw_axis[1] = afe_sample.y;
	assign raw_axis[2] = afe_sample.z;

	// One saturator per axis
	for (genvar i = 0; i < 3; i++)
	begin : g_axis
		mrc_sat16 #(
			.IN_W(mrc_pkg::RAW_W)
		) u_sat (
			.raw(raw_axis[i]),
			.value(sat_val[i]),
			.clipped(sat_clip[i])
		);
	end

	// Status byte
	wire [7:0] status_byte = {5'h00, result_overrun_flag, clip_flag, result_ready_flag};

	// Read view of the map; unmapped offsets read zero
	logic [7:0] reg_view [0:15];
	assign reg_view[0] = mag_x[7:0];
	assign reg_view[1] = mag_x[15:8];
	assign reg_view[2] = mag_y[7:0];
	assign reg_view[3] = mag_y[15:8];
	assign reg_view[4] = mag_z[7:0];
	assign reg_view[5] = mag_z[15:8];
	assign reg_view[6] = status_byte;
	assign reg_view[7] = temp[7:0];
	assign reg_view[8] = temp[15:8];
	assign reg_view[9] = ctrl;
	assign reg_view[10] = {1'b0, roll_en, 5'h00, int_dis};
	assign reg_view[11] = sr_period;
	assign reg_view[12] = 8'h00;
	assign reg_view[13] = 8'h00;
	assign reg_view[14] = 8'h00;
	assign reg_view[15] = 8'h00;
	wire [7:0] rd_byte = (ptr[7:4] == 4'h0) ? reg_view[ptr[3:0]] : 8'h00;

	// Measurement interval timer, halted outside continuous mode
	mrc_rate_timer #(
		.PERIOD0(PERIOD0),
		.PERIOD1(PERIOD1),
		.PERIOD2(PERIOD2),
		.PERIOD3(PERIOD3)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(measuring),
		.rate_sel(ctrl.output_rate),
		.tick(timer_tick)
	);

	// Front end configuration straight from the control fields; no start once standby is set
	assign afe_cfg = ctrl;
	assign afe_start = timer_tick && measuring;
	assign afe_sr_period = sr_period;

	// Open drain data line: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = oe;
	assign result_ready_pin = pin_q;

	// Previous line levels for edge and condition detection
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Serial slave engine; works at any bit rate up to fast mode
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= mrc_pkg::MRC_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			txbyte <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			first <= 1'b0;
			nack <= 1'b0;
			roll_on <= 1'b0;
			oe <= 1'b0;
		end
		else if (bus_start)
		begin
			state <= mrc_pkg::MRC_ADDR;
			cnt <= 4'h0;
			oe <= 1'b0;
		end
		else if (bus_stop)
		begin
			state <= mrc_pkg::MRC_IDLE;
			oe <= 1'b0;
		end
		else
		begin
			unique case (state)
				mrc_pkg::MRC_IDLE:
				begin
					oe <= 1'b0;
				end
				mrc_pkg::MRC_ADDR, mrc_pkg::MRC_RX:
				begin
					if (scl_rise)
					begin
						shreg <= {shreg[6:0], sda_in};
						cnt <= cnt + 4'h1;
					end
					else if (byte_done && state == mrc_pkg::MRC_ADDR)
					begin
						state <= addr_hit ? mrc_pkg::MRC_ACK_ADDR : mrc_pkg::MRC_IDLE;
						oe <= addr_hit;
						rw <= shreg[0];
					end
					else if (byte_done)
					begin
						state <= mrc_pkg::MRC_ACK_RX;
						oe <= 1'b1;
						ptr <= first ? shreg : ptr + 8'h01;
					end
				end
				mrc_pkg::MRC_ACK_ADDR:
				begin
					if (scl_fall && rw)
					begin
						state <= mrc_pkg::MRC_TX;
						txbyte <= rd_byte;
						oe <= !rd_byte[7];
						cnt <= 4'h0;
						roll_on <= roll_now;
						ptr <= next_ptr;
					end
					else if (scl_fall)
					begin
						state <= mrc_pkg::MRC_RX;
						oe <= 1'b0;
						cnt <= 4'h0;
						first <= 1'b1;
					end
				end
				mrc_pkg::MRC_ACK_RX:
				begin
					if (scl_fall)
					begin
						state <= mrc_pkg::MRC_RX;
						oe <= 1'b0;
						cnt <= 4'h0;
						first <= 1'b0;
					end
				end
				mrc_pkg::MRC_TX:
				begin
					if (scl_fall && cnt == 4'h7)
					begin
						state <= mrc_pkg::MRC_ACK_TX;
						oe <= 1'b0;
					end
					else if (scl_fall)
					begin
						oe <= !txbyte[6];
						txbyte <= {txbyte[6:0], 1'b0};
						cnt <= cnt + 4'h1;
					end
				end
				mrc_pkg::MRC_ACK_TX:
				begin
					if (scl_rise)
					begin
						nack <= sda_in;
					end
					else if (scl_fall && !nack)
					begin
						state <= mrc_pkg::MRC_TX;
						txbyte <= rd_byte;
						oe <= !rd_byte[7];
						cnt <= 4'h0;
						ptr <= next_ptr;
					end
					else if (scl_fall)
					begin
						state <= mrc_pkg::MRC_IDLE;
					end
				end
				default:
				begin
					state <= mrc_pkg::MRC_IDLE;
					oe <= 1'b0;
				end
			endcase
		end
	end

	// Writable control registers; soft reset restores all of them
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl <= `MRC_CTRL_RST;
			int_dis <= 1'b0;
			roll_en <= 1'b0;
			sr_period <= `MRC_SR_PERIOD_RST;
		end
		else if (soft_rst)
		begin
			ctrl <= `MRC_CTRL_RST;
			int_dis <= 1'b0;
			roll_en <= 1'b0;
			sr_period <= `MRC_SR_PERIOD_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= shreg;
			if (wr_ri)
				int_dis <= shreg[`MRC_RI_INT_DIS_BIT];
			if (wr_ri)
				roll_en <= shreg[`MRC_RI_ROLL_BIT];
			if (wr_sr)
				sr_period <= shreg;
		end
	end

	// Result registers, filled with compensated front end data
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mag_x <= 16'h0000;
			mag_y <= 16'h0000;
			mag_z <= 16'h0000;
			temp <= 16'h0000;
			clip_flag <= 1'b0;
		end
		else if (soft_rst)
		begin
			mag_x <= 16'h0000;
			mag_y <= 16'h0000;
			mag_z <= 16'h0000;
			temp <= 16'h0000;
			clip_flag <= 1'b0;
		end
		else if (update)
		begin
			mag_x <= sat_val[0];
			mag_y <= sat_val[1];
			mag_z <= sat_val[2];
			temp <= afe_sample.temp;
			clip_flag <= |sat_clip;
		end
	end

	// Ready, overrun and lock flags, and the data-ready pin
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result_ready_flag <= 1'b0;
			result_overrun_flag <= 1'b0;
			lock <= 1'b0;
			pin_q <= 1'b0;
		end
		else if (soft_rst)
		begin
			result_ready_flag <= 1'b0;
			result_overrun_flag <= 1'b0;
			lock <= 1'b0;
			pin_q <= 1'b0;
		end
		else
		begin
			result_ready_flag <= next_ready;
			result_overrun_flag <= next_overrun;
			lock <= next_lock;
			pin_q <= next_ready && !int_dis;
		end
	end
endmodule

// [testbench/magnetometer_readout_control_test.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module magnetometer_readout_control_test;
	localparam int P3 = 100;
	logic core_clk, rst_n, afe_valid;
	mrc_pkg::mrc_sample_t afe_sample;
	wire scl, pull, sda_out, sda_oe, pin, afe_start;
	mrc_pkg::mrc_ctrl_t afe_cfg;
	wire [7:0] afe_sr_period;
	wire sda = !((sda_oe & !sda_out) | pull);
	int n_fail, num_checks, cyc, k;
	logic [7:0] rb [0:8];
	logic [8:0] q;

	mrc_top #(.PERIOD3(P3)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .result_ready_pin(pin), .afe_start(afe_start), .afe_cfg(afe_cfg),
		.afe_sr_period(afe_sr_period), .afe_valid(afe_valid), .afe_sample(afe_sample));
	mrc_i2c_master host (.core_clk(core_clk), .sda(sda), .scl(scl), .pull(pull));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Hang guard
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			print_verdict;
		end
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Register write and burst read
	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		host.cond(1'b1);
		host.xfer({8'h1A, 1'b1}, q);
		`CHK(q[0], 1'b0)
		host.xfer({p, 1'b1}, q);
		host.xfer({v, 1'b1}, q);
		host.cond(1'b0);
	endtask
	task automatic rd(input logic [7:0] p, input int n);
		host.cond(1'b1);
		host.xfer({8'h1A, 1'b1}, q);
		host.xfer({p, 1'b1}, q);
		host.cond(1'b1);
		host.xfer({8'h1B, 1'b1}, q);
		`CHK(q[0], 1'b0)
		for (int i = 0; i < n; i++)
		begin
			host.xfer({8'hFF, i == n - 1}, q);
			rb[i] = q[8:1];
		end
		host.cond(1'b0);
	endtask
	task automatic exp(input logic [71:0] e, input int n);
		for (int i = 0; i < n; i++)
			`CHK(rb[i], e[71-8*i -: 8])
	endtask
	// One result set from the front end
	task automatic fe(input logic [19:0] x, input logic [19:0] y, input logic [19:0] z);
		@(posedge core_clk) afe_valid <= 1'b1;
		afe_sample <= '{x, y, z, 16'hABCD};
		@(posedge core_clk) afe_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic gap(output int c);
		c = 0;
		while (afe_start !== 1'b1 && c < 500)
		begin
			@(negedge core_clk);
			c++;
		end
	endtask

	task automatic t_reset;
		rd(8'h09, 3);
		exp(72'h000000, 3);
		host.cond(1'b1);
		host.xfer({8'h1C, 1'b1}, q);
		`CHK(q[0], 1'b1)
		host.cond(1'b0);
		fe(20'h1, 20'h2, 20'h3);
		rd(8'h06, 1);
		`CHK(rb[0], 8'h00)
		`CHK(pin, 1'b0)
	endtask
	task automatic t_meas;
		wr(8'h0B, 8'h01);
		`CHK(afe_sr_period, 8'h01)
		wr(8'h09, 8'h55);
		`CHK(afe_cfg, 8'h55)
		wr(8'h09, 8'h1D);
		`CHK(afe_cfg, 8'h1D)
		gap(k);
		@(negedge core_clk);
		gap(k);
		`CHK(k, P3 - 1)
		fe(20'h12345, 20'hFFFFB, 20'h80000);
		`CHK(pin, 1'b1)
		rd(8'h06, 1);
		`CHK(rb[0][0], 1'b1)
		`CHK(pin, 1'b1)
		rd(8'h00, 9);
		exp(72'hFF7FFBFF0080_00CDAB, 6);
		`CHK({rb[7], rb[8]}, 16'hCDAB)
		`CHK(rb[6] & 8'h05, 8'h00)
		`CHK(pin, 1'b0)
	endtask
	task automatic t_overrun;
		fe(20'h1, 20'h2, 20'h3);
		fe(20'h15, 20'h16, 20'h17);
		rd(8'h06, 1);
		`CHK(rb[0] & 8'h05, 8'h05)
		rd(8'h06, 1);
		`CHK(rb[0] & 8'h05, 8'h01)
		rd(8'h00, 6);
		exp(72'h150016001700_000000, 6);
	endtask
	task automatic t_lock;
		fe(20'h21, 20'h22, 20'h23);
		rd(8'h00, 1);
		fe(20'h31, 20'h32, 20'h33);
		rd(8'h06, 1);
		`CHK(rb[0] & 8'h05, 8'h04)
		rd(8'h00, 6);
		exp(72'h210022002300_000000, 6);
		fe(20'h41, 20'h42, 20'h43);
		rd(8'h00, 6);
		exp(72'h410042004300_000000, 6);
	endtask
	task automatic t_int_roll;
		wr(8'h0A, 8'h01);
		fe(20'h51, 20'h52, 20'h53);
		`CHK(pin, 1'b0)
		rd(8'h06, 1);
		`CHK(rb[0][0], 1'b1)
		wr(8'h0A, 8'h41);
		rd(8'h0A, 1);
		`CHK(rb[0], 8'h41)
		rd(8'h05, 3);
		`CHK(rb[2], 8'h51)
	endtask
	task automatic t_soft;
		// Result lands while locked, so overrun is up before the soft reset
		fe(20'h61, 20'h62, 20'h63);
		wr(8'h0A, 8'h80);
		`CHK(afe_cfg, 8'h00)
		rd(8'h09, 3);
		exp(72'h000000, 3);
		rd(8'h06, 1);
		`CHK(rb[0], 8'h00)
		wr(8'h09, 8'h1D);
		fe(20'h71, 20'h72, 20'h73);
		rd(8'h00, 1);
		`CHK(rb[0], 8'h71)
		wr(8'h09, 8'h00);
		k = 0;
		repeat (3 * P3)
		begin
			@(negedge core_clk);
			k += afe_start;
		end
		`CHK(k, 0)
	endtask

	initial
	begin
		rst_n = 1'b0;
		afe_valid = 1'b0;
		afe_sample = '0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset;
		t_meas;
		t_overrun;
		t_lock;
		t_int_roll;
		t_soft;
		print_verdict;
	end
endmodule

// [testbench/mrc_i2c_master.sv]
`timescale 1ns/10ps
module mrc_i2c_master (
	// Clock
	input wire logic core_clk,
	// Bus wires, data pulled up when released
	input wire logic sda,
	output logic scl,
	output logic pull
);
	// Bus idle with both lines released
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Start when s is 1, stop when s is 0; data preset with clock low, condition edge with clock high
	task automatic cond(input logic s);
		@(posedge core_clk) scl <= 1'b0;
		tick(3);
		pull <= !s;
		tick(3);
		scl <= 1'b1;
		tick(3);
		pull <= s;
		tick(3);
	endtask

	// One bit: data set while clock low, sampled late in the high phase
	task automatic bitx(input logic b, output logic r);
		@(posedge core_clk) scl <= 1'b0;
		tick(3);
		pull <= !b;
		tick(3);
		scl <= 1'b1;
		tick(3);
		r = sda;
		tick(1);
	endtask

	// Eight data bits and the acknowledge slot
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
			bitx(d[i], q[i]);
	endtask
endmodule

// [testbench/mrc_top_monitor.sv]
`timescale 1ns/10ps
`include "mrc_map.svh"
module mrc_top_monitor #(
	parameter int unsigned PERIOD0 = `MRC_PERIOD_US_R0 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD1 = `MRC_PERIOD_US_R1 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD2 = `MRC_PERIOD_US_R2 * `MRC_CLK_MHZ,
	parameter int unsigned PERIOD3 = `MRC_PERIOD_US_R3 * `MRC_CLK_MHZ
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus and pins
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic result_ready_pin,
	// Front end
	input wire logic afe_start,
	input wire mrc_pkg::mrc_ctrl_t afe_cfg,
	input wire logic [7:0] afe_sr_period,
	input wire logic afe_valid
);
	// Start spacing of the selected rate
	wire [31:0] per = afe_cfg.output_rate[1] ? (afe_cfg.output_rate[0] ? PERIOD3 : PERIOD2)
		: (afe_cfg.output_rate[0] ? PERIOD1 : PERIOD0);
	logic [31:0] since;
	logic armed;
	mrc_pkg::mrc_ctrl_t cfg_q;

	// Cycles since the last start under an unchanged setting
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			since <= 32'h0;
			armed <= 1'b0;
			cfg_q <= 8'h00;
		end
		else
		begin
			since <= afe_start ? 32'h0 : since + 32'h1;
			armed <= afe_start | (armed & (afe_cfg == cfg_q));
			cfg_q <= afe_cfg;
		end
	end

	default clocking mc @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// Open-drain data line moves only while the clock is low
	AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
		else $error("sda_out not low");
	AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda_oe moved while scl high");
	// Measurement starts
	AST_START_MODE: assert property (afe_start |-> afe_cfg.mode == 2'b01)
		else $error("start outside continuous mode");
	AST_START_PULSE: assert property (afe_start |=> !afe_start)
		else $error("start strobe longer than one cycle");
	AST_START_SPACING: assert property (afe_start && armed && afe_cfg == cfg_q |-> since == per - 32'h1)
		else $error("start spacing differs from rate period");
	// Ready pin
	AST_PIN_RISE: assert property ($rose(result_ready_pin) |-> $past(afe_valid) || !scl_in)
		else $error("ready pin rose without a result");
	AST_PIN_FALL: assert property ($fell(result_ready_pin) |-> !scl_in)
		else $error("ready pin fell outside a bus access");
	// Control register contents change only inside a bus transfer
	AST_CFG_BUS: assert property ($changed(afe_cfg) || $changed(afe_sr_period) |-> !scl_in)
		else $error("control changed outside a bus write");

	COV_START: cover property (afe_start);
	COV_PIN: cover property ($rose(result_ready_pin));
	COV_ACK: cover property ($rose(sda_oe));
endmodule

bind mrc_top mrc_top_monitor #(
	.PERIOD3(PERIOD3)
) u_mon (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.scl_in(scl_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.result_ready_pin(result_ready_pin),
	.afe_start(afe_start),
	.afe_cfg(afe_cfg),
	.afe_sr_period(afe_sr_period),
	.afe_valid(afe_valid)
);
